// ===== t16c_map.svh
// Register offsets, field positions and reset values of the capture timer
// How it works
// - Clock select picks tick; zero stops counter
// - Tick clears, increments or decrements; top, bottom
// - CPU counter write beats clear and count
// - Counter accessible with or without tick
// - Counter seen as two byte locations
// - High byte via holding register, low triggers
// - Four-bit mode field spans controls A, B
// - Overflow flag set per mode, interrupts
// - Matching trigger edge copies counter to capture
// - Capture flag set in copy cycle
// - Enabled flag interrupts; ack or one clears
// - Capture read low first via holding register
// - Capture writable only in capture-top modes
// - Comparator select switches trigger to comparator
// - Filter output changes after four equal samples
// - Filter enable adds five system clocks
// - Capture inputs off in capture-top modes
// - Port drive of capture pin triggers too
// - New capture overwrites unread value
// - Top is fixed, compare A or capture
// - Bottom at 0x0000, maximum at 0xFFFF
`ifndef T16C_MAP_SVH
`define T16C_MAP_SVH
`define T16C_A_CTRL_A   4'h0
`define T16C_A_CTRL_B   4'h1
`define T16C_A_CNT_LO   4'h2
`define T16C_A_CNT_HI   4'h3
`define T16C_A_CAP_LO   4'h4
`define T16C_A_CAP_HI   4'h5
`define T16C_A_CMPA_LO  4'h6
`define T16C_A_CMPA_HI  4'h7
`define T16C_A_FLAGS    4'h8
`define T16C_A_IRQ_EN   4'h9
`define T16C_A_CMP_CTRL 4'hA
`define T16C_B_OVF      0
`define T16C_B_CAP      1
`define T16C_B_FILT     7
`define T16C_B_EDGE     6
`define T16C_B_CMPSEL   0
`define T16C_RST_BYTE   8'h00
`define T16C_RST_WORD   16'h0000
`define T16C_TOP8       16'h00FF
`define T16C_TOP9       16'h01FF
`define T16C_TOP10      16'h03FF
`define T16C_MAXV       16'hFFFF
`define T16C_FILT_LEN   4
`endif

// ===== t16c_pkg.sv
// Types shared by the capture timer
package t16c_pkg;
    typedef enum logic {T16C_DOWN, T16C_UP} t16c_dir_e;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } t16c_bus_s;
    typedef struct packed {
        logic       val;
        logic       oe;
    } t16c_port_s;
endpackage

// ===== t16c_timer.sv
// 16-bit timer/counter with input capture, byte register port
`timescale 1ns/10ps
`include "t16c_map.svh"
module t16c_timer (
    input  wire logic                 core_clk_in,    // System clock
    input  wire logic                 rstn_in,        // Async reset, low
    input  wire t16c_pkg::t16c_bus_s  bus_in,         // Register access
    input  wire logic                 capture_pin_in, // Capture pin level
    input  wire t16c_pkg::t16c_port_s cap_port_in,    // Port drive of pin
    input  wire logic                 comparator_output_in, // Comparator
    input  wire logic                 external_count_pin_in, // Ext tick
    input  wire logic                 cap_ack_in,     // Capture irq served
    input  wire logic                 ovf_ack_in,     // Overflow irq served
    output logic [7:0]                rdata_out,      // Read data
    output logic                      cap_irq_out,    // Capture request
    output logic                      ovf_irq_out,    // Overflow request
    output logic                      top_out,        // Count at top
    output logic                      bottom_out      // Count at zero
);
    // Top value chosen by waveform mode
    function automatic logic [15:0] top_of(input logic [3:0] m,
            input logic [15:0] ocra, input logic [15:0] icr);
        logic [15:0] t;
        t = `T16C_MAXV;
        case (m)
            4'h1, 4'h5: t = `T16C_TOP8;
            4'h2, 4'h6: t = `T16C_TOP9;
            4'h3, 4'h7: t = `T16C_TOP10;
            4'h4, 4'h9, 4'hB, 4'hF: t = ocra;
            4'h8, 4'hA, 4'hC, 4'hE: t = icr;
            default: t = `T16C_MAXV;
        endcase
        return t;
    endfunction

    logic [7:0]  ctrl_a_reg, ctrl_b_reg, ie_reg, temp_reg, rdata_reg;
    logic [15:0] cnt_reg, icr_reg, ocra_reg;
    logic        ovf_reg, capf_reg, cmpsel_reg;
    logic        cap_irq_reg, ovf_irq_reg, top_reg, bottom_reg;
    t16c_pkg::t16c_dir_e dir_reg;
    logic [9:0]  pre_reg;
    logic        pin_s1, pin_s2, cmp_s1, cmp_s2, ext_s1, ext_s2, ext_prev;
    logic [3:0]  samp_reg;
    logic        filt_reg, edge_prev;

    // Address decode
    wire         wr = bus_in.wr;
    wire         rd = bus_in.rd;
    wire [3:0]   ad = bus_in.addr;
    wire [7:0]   wd = bus_in.wdata;
    wire         wr_cnt_lo = wr && ad == `T16C_A_CNT_LO;
    wire         rd_cnt_lo = rd && ad == `T16C_A_CNT_LO;
    wire         rd_cap_lo = rd && ad == `T16C_A_CAP_LO;
    wire         wr_cap_lo = wr && ad == `T16C_A_CAP_LO;
    wire         wr_hi = wr && (ad == `T16C_A_CNT_HI || ad == `T16C_A_CAP_HI
                        || ad == `T16C_A_CMPA_HI);
    wire         wr_flags = wr && ad == `T16C_A_FLAGS;

    // mode field split over A and B
    wire [3:0]   mode = {ctrl_b_reg[4:3], ctrl_a_reg[1:0]};
    wire [2:0]   cs = ctrl_b_reg[2:0];
    wire         updown = mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
                                       4'hA, 4'hB};
    wire         ctc = mode == 4'h4 || mode == 4'hC;
    wire         icr_top = mode inside {4'h8, 4'hA, 4'hC, 4'hE};
    wire [15:0]  top = top_of(mode, ocra_reg, icr_reg);
    wire         at_top = cnt_reg == top;
    wire         at_zero = cnt_reg == `T16C_RST_WORD;
    wire         at_max = cnt_reg == `T16C_MAXV;

    // tick source; zero yields no tick
    wire         ext_fall = ext_prev && !ext_s2;
    wire         ext_rise = !ext_prev && ext_s2;
    wire         tick = (cs == 3'h1)
                     || (cs == 3'h2 && pre_reg[2:0] == 3'h7)
                     || (cs == 3'h3 && pre_reg[5:0] == 6'h3F)
                     || (cs == 3'h4 && pre_reg[7:0] == 8'hFF)
                     || (cs == 3'h5 && pre_reg == 10'h3FF)
                     || (cs == 3'h6 && ext_fall)
                     || (cs == 3'h7 && ext_rise);

    wire         turn_dn = dir_reg == t16c_pkg::T16C_UP && at_top;
    wire         turn_up = dir_reg == t16c_pkg::T16C_DOWN && at_zero;
    wire         go_up = updown ? (turn_up || (dir_reg == t16c_pkg::T16C_UP
                                   && !turn_dn)) : 1'b1;
    wire [15:0]  step = updown ? (go_up ? cnt_reg + 16'h0001
                                        : cnt_reg - 16'h0001)
                               : (at_top ? `T16C_RST_WORD
                                         : cnt_reg + 16'h0001);
    wire [15:0]  cnt_next = wr_cnt_lo ? {temp_reg, wd}
                          : tick ? step : cnt_reg;
    wire         ovf_ev = tick && !wr_cnt_lo && (updown ? at_zero
                          : ctc ? at_max : at_top);

    // trigger source, port drive wins on the pin
    wire         pin_eff = cap_port_in.oe ? cap_port_in.val : pin_s2;
    wire         src = cmpsel_reg ? cmp_s2 : pin_eff;
    // four agreeing samples move the filter
    wire         all1 = &samp_reg;
    wire         all0 = ~|samp_reg;
    // filter inserted ahead of edge detector
    wire         edge_in = ctrl_b_reg[`T16C_B_FILT] ? filt_reg : src;
    // edge match, off in capture-top modes
    wire         cap_ev = !icr_top && (ctrl_b_reg[`T16C_B_EDGE]
                          ? (edge_in && !edge_prev)
                          : (!edge_in && edge_prev));

    wire         capf_next = cap_ev || (capf_reg && !cap_ack_in
                             && !(wr_flags && wd[`T16C_B_CAP]));
    wire         ovf_next = ovf_ev || (ovf_reg && !ovf_ack_in
                            && !(wr_flags && wd[`T16C_B_OVF]));

    wire [7:0]   temp_next = wr_hi ? wd
                           : rd_cnt_lo ? cnt_reg[15:8]
                           : rd_cap_lo ? icr_reg[15:8] : temp_reg;
    // capture copy and gated software write
    wire [15:0]  icr_next = cap_ev ? cnt_reg
                          : (wr_cap_lo && icr_top) ? {temp_reg, wd}
                          : icr_reg;
    wire [15:0]  ocra_next = (wr && ad == `T16C_A_CMPA_LO)
                           ? {temp_reg, wd} : ocra_reg;

    // read mux, counter and capture high bytes via holding register
    wire [7:0]   rmux = (ad == `T16C_A_CTRL_A) ? ctrl_a_reg
                      : (ad == `T16C_A_CTRL_B) ? ctrl_b_reg
                      : (ad == `T16C_A_CNT_LO) ? cnt_reg[7:0]
                      : (ad == `T16C_A_CAP_LO) ? icr_reg[7:0]
                      : (ad == `T16C_A_CNT_HI || ad == `T16C_A_CAP_HI)
                        ? temp_reg
                      : (ad == `T16C_A_CMPA_LO) ? ocra_reg[7:0]
                      : (ad == `T16C_A_CMPA_HI) ? ocra_reg[15:8]
                      : (ad == `T16C_A_FLAGS) ? {6'h00, capf_reg, ovf_reg}
                      : (ad == `T16C_A_IRQ_EN) ? {6'h00, ie_reg[1:0]}
                      : (ad == `T16C_A_CMP_CTRL) ? {7'h00, cmpsel_reg}
                      : `T16C_RST_BYTE;
    wire [7:0]   rdata_next = rd ? rmux : `T16C_RST_BYTE;

    // Control registers written by software
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_a_reg <= `T16C_RST_BYTE;
            ctrl_b_reg <= `T16C_RST_BYTE;
            ie_reg     <= `T16C_RST_BYTE;
            cmpsel_reg <= 1'b0;
        end else if (wr) begin
            if (ad == `T16C_A_CTRL_A) ctrl_a_reg <= wd;
            else if (ad == `T16C_A_CTRL_B) ctrl_b_reg <= wd;
            else if (ad == `T16C_A_IRQ_EN) ie_reg <= wd;
            else if (ad == `T16C_A_CMP_CTRL) cmpsel_reg <= wd[`T16C_B_CMPSEL];
        end
    end

    // Counter, direction, holding and data registers
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg  <= `T16C_RST_WORD;
            icr_reg  <= `T16C_RST_WORD;
            ocra_reg <= `T16C_RST_WORD;
            temp_reg <= `T16C_RST_BYTE;
            dir_reg  <= t16c_pkg::T16C_UP;
        end else begin
            cnt_reg  <= cnt_next;
            icr_reg  <= icr_next;
            ocra_reg <= ocra_next;
            temp_reg <= temp_next;
            if (!updown) dir_reg <= t16c_pkg::T16C_UP;
            else if (tick && !wr_cnt_lo)
                dir_reg <= go_up ? t16c_pkg::T16C_UP : t16c_pkg::T16C_DOWN;
        end
    end

    // Prescaler runs only while a source is selected
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) pre_reg <= 10'h000;
        else if (cs == 3'h0) pre_reg <= 10'h000;
        else pre_reg <= pre_reg + 10'h001;
    end

    // Two-stage synchronisers for pins and comparator
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {pin_s1, pin_s2, cmp_s1, cmp_s2} <= 4'h0;
            {ext_s1, ext_s2, ext_prev} <= 3'h0;
        end else begin
            {pin_s1, pin_s2} <= {capture_pin_in, pin_s1};
            {cmp_s1, cmp_s2} <= {comparator_output_in, cmp_s1};
            {ext_s1, ext_s2, ext_prev} <= {external_count_pin_in, ext_s1, ext_s2};
        end
    end

    // Filter sampled on system clock, not the prescaler
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            samp_reg  <= 4'h0;
            filt_reg  <= 1'b0;
            edge_prev <= 1'b0;
        end else begin
            samp_reg  <= {samp_reg[2:0], src};
            if (all1) filt_reg <= 1'b1;
            else if (all0) filt_reg <= 1'b0;
            edge_prev <= edge_in;
        end
    end

    // Flags, requests and registered outputs
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            capf_reg    <= 1'b0;
            ovf_reg     <= 1'b0;
            cap_irq_reg <= 1'b0;
            ovf_irq_reg <= 1'b0;
            top_reg     <= 1'b0;
            bottom_reg  <= 1'b1;
            rdata_reg   <= `T16C_RST_BYTE;
        end else begin
            capf_reg    <= capf_next;
            ovf_reg     <= ovf_next;
            cap_irq_reg <= capf_next && ie_reg[`T16C_B_CAP];
            ovf_irq_reg <= ovf_next && ie_reg[`T16C_B_OVF];
            top_reg     <= cnt_next == top;
            bottom_reg  <= cnt_next == `T16C_RST_WORD;
            rdata_reg   <= rdata_next;
        end
    end

    assign rdata_out   = rdata_reg;
    assign cap_irq_out = cap_irq_reg;
    assign ovf_irq_out = ovf_irq_reg;
    assign top_out     = top_reg;
    assign bottom_out  = bottom_reg;

    // Checks on the timer and capture behaviour
    property p_cpu_wins;
        @(posedge core_clk_in) disable iff (!rstn_in)
        wr_cnt_lo |=> cnt_reg == {$past(temp_reg), $past(wd)};
    endproperty
    a_cpu_wins: assert property (p_cpu_wins) else $error("counter write lost");
    property p_stopped;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (cs == 3'h0 && !wr_cnt_lo) |=> $stable(cnt_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped counter moved");
    property p_cap_copy;
        @(posedge core_clk_in) disable iff (!rstn_in)
        cap_ev |=> capf_reg && icr_reg == $past(cnt_reg);
    endproperty
    a_cap_copy: assert property (p_cap_copy) else $error("capture copy wrong");
    property p_temp_load;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (rd_cnt_lo && !wr_hi) |=> temp_reg == $past(cnt_reg[15:8]);
    endproperty
    a_temp_load: assert property (p_temp_load) else $error("holding byte wrong");
    property p_ack_clear;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (cap_ack_in && !cap_ev) |=> !capf_reg && !cap_irq_reg;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("capture flag kept");
    property p_cap_guard;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (wr_cap_lo && !icr_top && !cap_ev) |=> $stable(icr_reg);
    endproperty
    a_cap_guard: assert property (p_cap_guard) else $error("capture write leaked");
    property p_cap_off;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (icr_top && !wr_cap_lo) |=> $stable(icr_reg);
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("capture in top mode");
    property p_bottom;
        @(posedge core_clk_in) disable iff (!rstn_in)
        bottom_out == (cnt_reg == `T16C_RST_WORD);
    endproperty
    a_bottom: assert property (p_bottom) else $error("bottom mismatch");
    property p_up_step;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (tick && !wr_cnt_lo && !updown && !at_top) |=> cnt_reg == $past(cnt_reg) + 16'h0001;
    endproperty
    a_up_step: assert property (p_up_step) else $error("count step wrong");
    property p_ovf_set;
        @(posedge core_clk_in) disable iff (!rstn_in)
        ovf_ev |=> ovf_reg;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missing");
    c_capture: cover property (@(posedge core_clk_in) disable iff (!rstn_in) cap_ev);
    c_overflow: cover property (@(posedge core_clk_in) disable iff (!rstn_in) ovf_ev);
    c_turn: cover property (@(posedge core_clk_in) disable iff (!rstn_in) tick && turn_dn);
endmodule

// ===== t16c_cpu_model.sv
// CPU bus master model for the capture timer register port
`timescale 1ns/10ps
module t16c_cpu_model (
    input  wire logic           core_clk_in, // System clock
    input  wire logic [7:0]     rdata_in,    // Read data
    output t16c_pkg::t16c_bus_s bus_out,     // Register access
    output logic                cap_ack_out, // Capture irq served
    output logic                ovf_ack_out  // Overflow irq served
);
    // Idle bus at time zero
    initial begin
        bus_out     = '0;
        cap_ack_out = 1'b0;
        ovf_ack_out = 1'b0;
    end
    // Released bus carries junk, so a stale address never looks valid
    task automatic idle();
        bus_out <= '{4'($urandom), 8'($urandom), 1'b0, 1'b0};
    endtask
    // Strobe held one cycle, released after the taking edge
    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        bus_out <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk_in);
        idle();
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd8(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        bus_out <= '{a, 8'($urandom), 1'b0, 1'b1};
        @(posedge core_clk_in);
        idle();
        @(negedge core_clk_in);
        d = rdata_in;
    endtask
    // high then low, no gap use
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        wr8(lo + 4'h1, v[15:8]);
        wr8(lo, v[7:0]);
    endtask
    task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
        rd8(lo, v[7:0]);
        rd8(lo + 4'h1, v[15:8]);
    endtask
    // One-cycle interrupt service pulse
    task automatic ack(input logic is_cap);
        @(posedge core_clk_in);
        cap_ack_out <= is_cap;
        ovf_ack_out <= ~is_cap;
        @(posedge core_clk_in);
        cap_ack_out <= 1'b0;
        ovf_ack_out <= 1'b0;
    endtask
endmodule

// ===== tb.sv
// Self-checking testbench for the 16-bit capture timer
`timescale 1ns/10ps
`include "t16c_map.svh"
module tb;
    logic                 core_clk_in;
    logic                 rstn_in;
    t16c_pkg::t16c_bus_s  bus;
    logic                 pin;
    t16c_pkg::t16c_port_s cap_port;
    logic                 cmp_out;
    logic                 ext_pin;
    logic                 cap_ack;
    logic                 ovf_ack;
    logic [7:0]           rdata;
    logic                 cap_irq;
    logic                 ovf_irq;
    logic                 top;
    logic                 bottom;
    logic [7:0]           f;
    logic [15:0]          v;
    logic [15:0]          w;
    int                   n;
    int                   n_mismatch  = 0;
    int                   check_count = 0;
    logic [3:0]           modes [5]   = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7};
    t16c_timer t16c_timer_inst (
        .core_clk_in           (core_clk_in),
        .rstn_in               (rstn_in),
        .bus_in                (bus),
        .capture_pin_in        (pin),
        .cap_port_in           (cap_port),
        .comparator_output_in  (cmp_out),
        .external_count_pin_in (ext_pin),
        .cap_ack_in            (cap_ack),
        .ovf_ack_in            (ovf_ack),
        .rdata_out             (rdata),
        .cap_irq_out           (cap_irq),
        .ovf_irq_out           (ovf_irq),
        .top_out               (top),
        .bottom_out            (bottom)
    );
    t16c_cpu_model t16c_cpu_model_inst (
        .core_clk_in (core_clk_in),
        .rdata_in    (rdata),
        .bus_out     (bus),
        .cap_ack_out (cap_ack),
        .ovf_ack_out (ovf_ack)
    );
    // System clock, 8 ns period
    initial core_clk_in = 1'b0;
    always #4 core_clk_in = ~core_clk_in;
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp16({8'h00, got}, {8'h00, exp});
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp16({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Expected control B image and top value per mode
    function automatic logic [7:0] ctl_b(input logic [3:0] m, input logic [2:0] cs,
                                         input logic filt, input logic edg);
        return {filt, edg, 1'b0, m[3:2], cs};
    endfunction
    function automatic logic [15:0] top_of(input logic [3:0] m);
        case (m)
            4'h4:    return 16'h0ABC;
            4'h5:    return `T16C_TOP8;
            4'h6:    return `T16C_TOP9;
            4'h7:    return `T16C_TOP10;
            default: return `T16C_MAXV;
        endcase
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        t16c_cpu_model_inst.wr8(a, d);
    endtask
    task automatic wr16(input logic [3:0] a, input logic [15:0] d);
        t16c_cpu_model_inst.wr16(a, d);
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] d);
        t16c_cpu_model_inst.rd16(a, d);
    endtask
    task automatic ctl(input logic [3:0] m, input logic [2:0] cs, input logic filt,
                       input logic edg);
        wr(`T16C_A_CTRL_A, {6'h00, m[1:0]});
        wr(`T16C_A_CTRL_B, ctl_b(m, cs, filt, edg));
    endtask
    // Move one trigger source, then check flag and, when chk is 2, captured word
    task automatic cap_try(input int src, input logic lvl, input int chk, input logic [15:0] cv);
        wr16(`T16C_A_CNT_LO, cv);
        wr(`T16C_A_FLAGS, 8'h02);
        @(posedge core_clk_in);
        if (src == 0) pin <= lvl;
        else if (src == 1) cmp_out <= lvl;
        else cap_port <= '{lvl, 1'b1};
        repeat (12) @(posedge core_clk_in);
        t16c_cpu_model_inst.rd8(`T16C_A_FLAGS, f);
        cmp8(f & 8'h02, (chk > 0) ? 8'h02 : 8'h00);
        rd16(`T16C_A_CAP_LO, w);
        if (chk == 2) cmp16(w, cv);
    endtask
    // Watchdog far beyond the expected run length
    initial begin
        repeat (20000) @(posedge core_clk_in);
        n_mismatch++;
        end_sim();
    end
    initial begin
        void'($urandom(76113));
        {rstn_in, pin, cap_port, cmp_out, ext_pin} = '0;
        repeat (2) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        cmp1(bottom, 1'b1);
        // Stopped counter: boundary and random words
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr16(`T16C_A_CNT_LO, v);
            rd16(`T16C_A_CNT_LO, w);
            cmp16(w, v);
        end
        // Holding byte reused for compare A
        wr(`T16C_A_CMPA_LO, ~v[7:0]);
        rd16(`T16C_A_CMPA_LO, w);
        cmp16(w, {v[15:8], ~v[7:0]});
        wr16(`T16C_A_CMPA_LO, 16'h0ABC);
        foreach (modes[i]) begin
            ctl(modes[i], 3'h0, 1'b0, 1'b0);
            wr16(`T16C_A_CNT_LO, top_of(modes[i]));
            repeat (2) @(posedge core_clk_in);
            cmp1(top, 1'b1);
            wr16(`T16C_A_CNT_LO, top_of(modes[i]) - 16'h0001);
            repeat (2) @(posedge core_clk_in);
            cmp1(top, 1'b0);
        end
        // External rising ticks, random count
        ctl(4'h0, 3'h7, 1'b0, 1'b0);
        wr16(`T16C_A_CNT_LO, 16'h0000);
        n = 1 + ($urandom % 6);
        repeat (2 * n) begin
            @(posedge core_clk_in);
            ext_pin <= ~ext_pin;
            repeat (4) @(posedge core_clk_in);
        end
        ctl(4'h0, 3'h0, 1'b0, 1'b0);
        rd16(`T16C_A_CNT_LO, w);
        cmp16(w, 16'(n));
        // Write while running wins; stopped counter holds
        ctl(4'h0, 3'h1, 1'b0, 1'b0);
        wr16(`T16C_A_CNT_LO, 16'h4000);
        ctl(4'h0, 3'h0, 1'b0, 1'b0);
        rd16(`T16C_A_CNT_LO, v);
        cmp1(v >= 16'h4000 && v < 16'h4010, 1'b1);
        repeat (10) @(posedge core_clk_in);
        rd16(`T16C_A_CNT_LO, w);
        cmp16(w, v);
        // Dual slope: top, then bottom, overflow there
        wr16(`T16C_A_CNT_LO, 16'h00F0);
        ctl(4'h1, 3'h1, 1'b0, 1'b0);
        for (n = 0; n < 600 && top !== 1'b1; n++) @(posedge core_clk_in);
        cmp1(top, 1'b1);
        for (n = 0; n < 600 && bottom !== 1'b1; n++) @(posedge core_clk_in);
        cmp1(bottom, 1'b1);
        ctl(4'h1, 3'h0, 1'b0, 1'b0);
        wr(`T16C_A_IRQ_EN, 8'h01);
        repeat (2) @(posedge core_clk_in);
        cmp1(ovf_irq, 1'b1);
        t16c_cpu_model_inst.ack(1'b0);
        repeat (2) @(posedge core_clk_in);
        cmp1(ovf_irq, 1'b0);
        // Normal mode wrap, cleared by writing one
        wr16(`T16C_A_CNT_LO, 16'hFFF8);
        ctl(4'h0, 3'h1, 1'b0, 1'b1);
        // Twelve ticks in all, enough to pass the wrap from the maximum
        repeat (8) @(posedge core_clk_in);
        ctl(4'h0, 3'h0, 1'b0, 1'b1);
        t16c_cpu_model_inst.rd8(`T16C_A_FLAGS, f);
        cmp8(f, 8'h01);
        wr(`T16C_A_FLAGS, 8'h01);
        // Edge select, rising then falling trigger edge
        cap_try(0, 1'b1, 1, 16'($urandom));
        cap_try(0, 1'b0, 0, 16'($urandom));
        cap_try(0, 1'b1, 2, 16'($urandom));
        ctl(4'h0, 3'h0, 1'b0, 1'b0);
        cap_try(0, 1'b0, 2, 16'($urandom));
        cap_try(0, 1'b1, 0, 16'($urandom));
        // Interrupt follows flag; service clears it
        wr(`T16C_A_IRQ_EN, 8'h02);
        pin <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        cmp1(cap_irq, 1'b1);
        t16c_cpu_model_inst.ack(1'b1);
        repeat (2) @(posedge core_clk_in);
        cmp1(cap_irq, 1'b0);
        // Filter: short glitch ignored, clean edge late
        ctl(4'h0, 3'h0, 1'b1, 1'b0);
        pin <= 1'b1;
        repeat (12) @(posedge core_clk_in);
        wr(`T16C_A_FLAGS, 8'h02);
        pin <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        pin <= 1'b1;
        repeat (12) @(posedge core_clk_in);
        cmp1(cap_irq, 1'b0);
        pin <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        cmp1(cap_irq, 1'b0);
        repeat (6) @(posedge core_clk_in);
        cmp1(cap_irq, 1'b1);
        // Comparator as source, then port drive of the pin
        ctl(4'h0, 3'h0, 1'b0, 1'b1);
        wr(`T16C_A_CMP_CTRL, 8'h01);
        cap_try(0, 1'b1, 0, 16'($urandom));
        cap_try(1, 1'b1, 2, 16'($urandom));
        wr(`T16C_A_CMP_CTRL, 8'h00);
        cap_try(2, 1'b0, 0, 16'($urandom));
        cap_try(2, 1'b1, 2, 16'($urandom));
        // Capture-top mode: writable, trigger ignored
        ctl(4'hC, 3'h0, 1'b0, 1'b1);
        t16c_cpu_model_inst.rd8(`T16C_A_CTRL_B, f);
        cmp8(f, ctl_b(4'hC, 3'h0, 1'b0, 1'b1));
        cap_try(2, 1'b0, 0, 16'($urandom));
        cap_try(2, 1'b1, 0, 16'($urandom));
        v = 16'($urandom);
        wr16(`T16C_A_CAP_LO, v);
        rd16(`T16C_A_CAP_LO, w);
        cmp16(w, v);
        ctl(4'h0, 3'h0, 1'b0, 1'b1);
        wr16(`T16C_A_CAP_LO, ~v);
        rd16(`T16C_A_CAP_LO, w);
        cmp16(w, v);
        end_sim();
    end
endmodule
